// ===== src/arcf_pkg.sv
// Constants, register map and carrier types of the converter result block.
// Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
package arcf_pkg;
	// ---------------------------------------------------------------
	// Register map, byte addresses
	// ---------------------------------------------------------------
	localparam logic [31:0] A_CUR  = 32'hFFFF0520;
	localparam logic [31:0] A_VOLT = 32'hFFFF0524;
	localparam logic [31:0] A_TEMP = 32'hFFFF0528;
	localparam logic [31:0] A_FIFO = 32'hFFFF052C;
	localparam logic [31:0] A_COFS = 32'hFFFF0530;
	localparam logic [31:0] A_VOFS = 32'hFFFF0534;
	localparam logic [31:0] A_RCL  = 32'hFFFF0548;
	localparam logic [31:0] A_RCV  = 32'hFFFF054C;
	localparam logic [31:0] A_TH   = 32'hFFFF0550;
	localparam logic [31:0] A_TCL  = 32'hFFFF0554;
	localparam logic [31:0] A_THV  = 32'hFFFF0558;
	localparam logic [31:0] A_CFG  = 32'hFFFF0580;
	localparam logic [31:0] A_STA  = 32'hFFFF0584;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CFG_RC     = 0;
	localparam int CFG_FIFO   = 1;
	localparam int CFG_OVR    = 2;
	localparam int CFG_CMP_LO = 3;
	localparam int CFG_CMP_HI = 4;
	localparam int NCH        = 3;
	localparam int CH_CUR     = 0;
	localparam int CH_VOLT    = 1;
	localparam int CH_TEMP    = 2;

	// ---------------------------------------------------------------
	// Reset values and limits
	// ---------------------------------------------------------------
	localparam logic [7:0]  CFG_RST = 8'h00;
	localparam logic [7:0]  TCL_RST = 8'h01;
	localparam logic [7:0]  THV_MAX = 8'hFF;
	localparam logic [15:0] RCL_RST = 16'h0001;
	localparam logic [15:0] TH_RST  = 16'h0000;
	localparam logic [15:0] DAT_RST = 16'h0000;
	localparam int          FIFO_DEPTH = 32;
	localparam int          FIFO_AW    = 5;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int              CLK_NS  = 40;
	localparam int              OVR_NS  = 125000;
	localparam int              OVR_CYC = (OVR_NS + CLK_NS - 1) / CLK_NS;
	localparam int              OVR_W   = 12;
	localparam logic [OVR_W-1:0] OVR_LIM = OVR_W'(OVR_CYC);

	// ---------------------------------------------------------------
	// Bus answers and types
	// ---------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		CMP_OFF     = 2'h0,
		CMP_ABS     = 2'h1,
		CMP_CNT_CLR = 2'h2,
		CMP_CNT_DEC = 2'h3
	} arcf_cmp_t;

	// One conversion result or calibration load, valid for one cycle
	typedef struct packed {
		logic        vld;
		logic [15:0] data;
	} arcf_res_t;
endpackage

// ===== src/arcf_fifo.sv
// Paired current/voltage result store, 32 words of 32 bits.
// Assumes push and pop come from the same clock; head is combinational.
`timescale 1ns/10ps
`default_nettype none
module arcf_fifo
	import arcf_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Control
	input  wire logic        flush,
	input  wire logic        push,
	input  wire logic [31:0] din,
	input  wire logic        pop,
	// State
	output logic      [31:0] head,
	output logic             empty,
	output logic             full
);
	logic [31:0]      mem [FIFO_DEPTH];
	logic [FIFO_AW:0] wp_r;
	logic [FIFO_AW:0] rp_r;

	// ---------------------------------------------------------------
	// Flags from pointer compare; the extra bit tells full from empty
	// ---------------------------------------------------------------
	assign empty = (wp_r == rp_r);
	assign full  = (wp_r[FIFO_AW] != rp_r[FIFO_AW]) && (wp_r[FIFO_AW-1:0] == rp_r[FIFO_AW-1:0]);
	assign head  = mem[rp_r[FIFO_AW-1:0]];

	// Storage; a push when full is dropped rather than overwriting
	always_ff @(posedge aclk)
	begin
		if (push && !full)
			mem[wp_r[FIFO_AW-1:0]] <= din;
	end

	// Pointers
	always_ff @(posedge aclk)
	begin
		if (!aresetn || flush)
		begin
			wp_r <= '0;
			rp_r <= '0;
		end
		else
		begin
			if (push && !full)
				wp_r <= wp_r + 1'b1;
			if (pop && !empty)
				rp_r <= rp_r + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== src/arcf_top.sv
// Converter result handling: data registers, comparator, overrange, FIFO.
// Assumes converter results arrive as one-cycle strobes on aclk; the
// overrange comparator output is asynchronous and is synchronised here.
`timescale 1ns/10ps
`default_nettype none
module arcf_top
	import arcf_pkg::*;
#(
	parameter logic [15:0] COFS_INIT = 16'h8000,
	parameter logic [15:0] VOFS_INIT = 16'h8000
)(
	// Clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// AXI4-Lite write
	input  wire logic [31:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// AXI4-Lite read
	input  wire logic [31:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// Converter side
	input  wire arcf_res_t [NCH-1:0]  res_in,
	input  wire logic                 cur_active,
	input  wire logic                 cur_reconfig,
	input  wire logic                 ovr_pin,
	input  wire arcf_res_t            cofs_cal,
	input  wire arcf_res_t            vofs_cal,
	output logic                      adc_irq
);
	// ---------------------------------------------------------------
	// Decoding helpers
	// ---------------------------------------------------------------
	function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
		hit = (a[31:2] == off[31:2]);
	endfunction

	function automatic logic mapped(input logic [31:0] a);
		mapped = hit(a, A_CUR) || hit(a, A_VOLT) || hit(a, A_TEMP) || hit(a, A_FIFO)
			|| hit(a, A_COFS) || hit(a, A_VOFS) || hit(a, A_RCL) || hit(a, A_RCV)
			|| hit(a, A_TH) || hit(a, A_TCL) || hit(a, A_THV) || hit(a, A_CFG) || hit(a, A_STA);
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] o, input logic [31:0] d,
		input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic            aw_r, w_r, bvalid_r, rvalid_r;
	logic [31:0]     waddr_r, wdata_r, rdata_r, rd_data;
	logic [3:0]      wstrb_r;
	logic [1:0]      bresp_r, rresp_r;
	logic            wr_go, rd_go, rd_cur, rd_volt, rd_temp, rd_sta;
	logic [7:0]      cfg_r, tcl_r, thv_r, thv_nxt, sta;
	logic [15:0]     th_r, rcl_r, rcv_r, rcv_nxt, cofs_r, vofs_r, cur_abs;
	logic [NCH-1:0]  rdy_r, rdy_clr;
	logic            ge, thr_evt, thr_r, rc_hit, irq_r;
	arcf_cmp_t       cmp_mode;
	arcf_res_t       cur;
	logic [2:0]      ovr_s_r;
	logic            ovr_lvl_r, ovr_r, ovr_evt;
	logic [OVR_W-1:0] ovr_cnt_r;
	logic            f_push, f_pop, f_empty, f_full, fovf_r;
	logic [31:0]     f_head;

	// ---------------------------------------------------------------
	// AXI4-Lite slave, one write and one read in flight
	// ---------------------------------------------------------------
	assign s_axi_awready = !aw_r && !bvalid_r;
	assign s_axi_wready  = !w_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign wr_go         = aw_r && w_r && !bvalid_r;
	assign rd_go         = s_axi_arvalid && !rvalid_r;
	assign rd_cur        = rd_go && hit(s_axi_araddr, A_CUR);
	assign rd_volt       = rd_go && hit(s_axi_araddr, A_VOLT);
	assign rd_temp       = rd_go && hit(s_axi_araddr, A_TEMP);
	assign rd_sta        = rd_go && hit(s_axi_araddr, A_STA);

	// Address and data are latched in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_r <= 1'b0;
			w_r  <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_r    <= 1'b1;
				waddr_r <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_r <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_r     <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			else if (wr_go)
				w_r <= 1'b0;
		end
	end

	// Write answer; read-only hits are quietly ignored
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_r <= 1'b1;
			bresp_r  <= mapped(waddr_r) ? RESP_OKAY : RESP_DECERR;
		end
		else if (s_axi_bready)
			bvalid_r <= 1'b0;
	end

	// Read mux
	assign sta = {fovf_r, f_full, !f_empty, ovr_r, thr_r, rdy_r};
	always_comb
	begin
		rd_data = '0;
		if (hit(s_axi_araddr, A_CUR))
			rd_data[15:0] = ch_g[CH_CUR].dat_r;
		else if (hit(s_axi_araddr, A_VOLT))
			rd_data[15:0] = ch_g[CH_VOLT].dat_r;
		else if (hit(s_axi_araddr, A_TEMP))
			rd_data[15:0] = ch_g[CH_TEMP].dat_r;
		else if (hit(s_axi_araddr, A_FIFO))
			rd_data = f_head;
		else if (hit(s_axi_araddr, A_COFS))
			rd_data[15:0] = cofs_r;
		else if (hit(s_axi_araddr, A_VOFS))
			rd_data[15:0] = vofs_r;
		else if (hit(s_axi_araddr, A_RCL))
			rd_data[15:0] = rcl_r;
		else if (hit(s_axi_araddr, A_RCV))
			rd_data[15:0] = rcv_r;
		else if (hit(s_axi_araddr, A_TH))
			rd_data[15:0] = th_r;
		else if (hit(s_axi_araddr, A_TCL))
			rd_data[7:0] = tcl_r;
		else if (hit(s_axi_araddr, A_THV))
			rd_data[7:0] = thv_r;
		else if (hit(s_axi_araddr, A_CFG))
			rd_data[7:0] = cfg_r;
		else if (hit(s_axi_araddr, A_STA))
			rd_data[7:0] = sta;
	end

	// Read answer, one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= RESP_OKAY;
		end
		else if (rd_go)
		begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_data;
			rresp_r  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
		end
		else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

	// ---------------------------------------------------------------
	// Software registers; calibration beats a software write
	// ---------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_r  <= CFG_RST;
			tcl_r  <= TCL_RST;
			th_r   <= TH_RST;
			rcl_r  <= RCL_RST;
			cofs_r <= COFS_INIT;
			vofs_r <= VOFS_INIT;
		end
		else
		begin
			if (wr_go && hit(waddr_r, A_CFG) && wstrb_r[0])
				cfg_r <= wdata_r[7:0];
			if (wr_go && hit(waddr_r, A_TCL) && wstrb_r[0])
				tcl_r <= wdata_r[7:0];
			if (wr_go && hit(waddr_r, A_TH))
				th_r <= merge16(th_r, wdata_r, wstrb_r);
			if (wr_go && hit(waddr_r, A_RCL))
				rcl_r <= merge16(rcl_r, wdata_r, wstrb_r);
			if (cofs_cal.vld)
				cofs_r <= cofs_cal.data;
			else if (wr_go && hit(waddr_r, A_COFS))
				cofs_r <= merge16(cofs_r, wdata_r, wstrb_r);
			if (vofs_cal.vld)
				vofs_r <= vofs_cal.data;
			else if (wr_go && hit(waddr_r, A_VOFS))
				vofs_r <= merge16(vofs_r, wdata_r, wstrb_r);
		end
	end

	// ---------------------------------------------------------------
	// Channel data and ready flags
	// ---------------------------------------------------------------
	assign rdy_clr[CH_CUR]  = rd_cur;
	assign rdy_clr[CH_VOLT] = rd_cur || (rd_volt && !cur_active);
	assign rdy_clr[CH_TEMP] = rdy_clr[CH_VOLT] || rd_temp;

	// A new result in the clearing cycle still lands; one arriving while the flag is set and not cleared is dropped
	for (genvar g = 0; g < NCH; g++)
	begin : ch_g
		logic [15:0] dat_r;
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				rdy_r[g] <= 1'b0;
				dat_r    <= DAT_RST;
			end
			else
			begin
				if (res_in[g].vld)
					rdy_r[g] <= 1'b1;
				else if (rdy_clr[g])
					rdy_r[g] <= 1'b0;
				if (res_in[g].vld && (!rdy_r[g] || rdy_clr[g]))
					dat_r <= res_in[g].data;
			end
		end
	end

	// ---------------------------------------------------------------
	// Threshold comparator on the absolute current result
	// ---------------------------------------------------------------
	assign cur      = res_in[CH_CUR];
	assign cur_abs  = cur.data[15] ? 16'(-cur.data) : cur.data;
	assign ge       = cur_abs >= th_r;
	assign cmp_mode = arcf_cmp_t'(cfg_r[CFG_CMP_HI:CFG_CMP_LO]);

	always_comb
	begin
		thv_nxt = thv_r;
		thr_evt = 1'b0;
		unique case (cmp_mode)
			CMP_OFF: thv_nxt = thv_r;
			CMP_ABS, CMP_CNT_CLR, CMP_CNT_DEC:
			begin
				if (cur.vld && ge)
					thv_nxt = (thv_r == THV_MAX) ? thv_r : thv_r + 8'h01;
				else if (cur.vld && cmp_mode == CMP_CNT_DEC)
					thv_nxt = (thv_r == '0) ? thv_r : thv_r - 8'h01;
				else if (cur.vld)
					thv_nxt = '0;
				if (cmp_mode == CMP_ABS)
					thr_evt = cur.vld && ge;
				else
					thr_evt = cur.vld && ge && (thv_nxt == tcl_r);
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			thv_r <= '0;
		else
			thv_r <= thv_nxt;
	end

	// ---------------------------------------------------------------
	// Result counter; divides the current interrupt rate
	// ---------------------------------------------------------------
	assign rcv_nxt = rcv_r + 16'h0001;
	assign rc_hit  = cur.vld && cfg_r[CFG_RC] && (rcv_nxt == rcl_r);

	always_ff @(posedge aclk)
	begin
		if (!aresetn || cur_reconfig)
			rcv_r <= '0;
		else if (cur.vld && cfg_r[CFG_RC])
			rcv_r <= rc_hit ? '0 : rcv_nxt;
	end

	// Interrupt: held until the current result or status is read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_r <= 1'b0;
		else if ((cfg_r[CFG_RC] ? rc_hit : cur.vld) || thr_evt)
			irq_r <= 1'b1;
		else if (rd_cur || rd_sta)
			irq_r <= 1'b0;
	end
	assign adc_irq = irq_r;

	// ---------------------------------------------------------------
	// Coarse overrange: synchronise, then time the level
	// ---------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ovr_s_r   <= '0;
			ovr_lvl_r <= 1'b0;
		end
		else
		begin
			ovr_s_r <= {ovr_s_r[1:0], ovr_pin};
			if (ovr_s_r[1] == ovr_s_r[2])
				ovr_lvl_r <= ovr_s_r[2];
		end
	end

	// Flag only once held past the limit; short glitches never count
	assign ovr_evt = cfg_r[CFG_OVR] && ovr_lvl_r && (ovr_cnt_r == OVR_LIM);
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !cfg_r[CFG_OVR] || !ovr_lvl_r)
			ovr_cnt_r <= '0;
		else if (ovr_cnt_r != OVR_LIM)
			ovr_cnt_r <= ovr_cnt_r + 1'b1;
	end

	// Sticky status flags, cleared by a status read, set wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			thr_r  <= 1'b0;
			ovr_r  <= 1'b0;
			fovf_r <= 1'b0;
		end
		else
		begin
			thr_r  <= thr_evt || (thr_r && !rd_sta);
			ovr_r  <= ovr_evt || (ovr_r && !rd_sta);
			fovf_r <= (f_push && f_full) || (fovf_r && !rd_sta);
		end
	end

	// ---------------------------------------------------------------
	// Paired result FIFO
	// ---------------------------------------------------------------
	assign f_push = cur.vld && cfg_r[CFG_FIFO];
	assign f_pop  = rd_go && hit(s_axi_araddr, A_FIFO);

	arcf_fifo u_fifo (
		.aclk    (aclk),
		.aresetn (aresetn),
		.flush   (!cfg_r[CFG_FIFO]),
		.push    (f_push),
		.din     ({res_in[CH_VOLT].data, cur.data}),
		.pop     (f_pop),
		.head    (f_head),
		.empty   (f_empty),
		.full    (f_full)
	);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_cnt_hit;
		cur.vld && cmp_mode[1] && ge && (thv_nxt == tcl_r);
	endsequence
	sequence s_rd_cur_quiet;
		rd_cur && !res_in[CH_CUR].vld && !res_in[CH_VOLT].vld && !res_in[CH_TEMP].vld;
	endsequence

	property p_cmp_off;
		cmp_mode == CMP_OFF |-> !thr_evt;
	endproperty
	a_cmp_off: assert property (p_cmp_off) else $error("threshold event while off");
	property p_abs;
		cur.vld && cmp_mode == CMP_ABS && ge |=> thr_r && adc_irq;
	endproperty
	a_abs: assert property (p_abs) else $error("threshold hit not flagged");
	property p_cnt;
		s_cnt_hit |=> thr_r && adc_irq && thv_r == tcl_r;
	endproperty
	a_cnt: assert property (p_cnt) else $error("count limit not flagged");
	property p_clr;
		cur.vld && cmp_mode == CMP_CNT_CLR && !ge |=> thv_r == '0;
	endproperty
	a_clr: assert property (p_clr) else $error("counter not cleared");
	property p_dec;
		cur.vld && cmp_mode == CMP_CNT_DEC && !ge && thv_r != '0 |=> thv_r == $past(thv_r) - 8'h01;
	endproperty
	a_dec: assert property (p_dec) else $error("counter not decremented");
	property p_ovr;
		ovr_evt |=> ovr_r && ovr_cnt_r == OVR_LIM;
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrange not flagged");
	property p_push;
		f_push && !f_full |=> !f_empty;
	endproperty
	a_push: assert property (p_push) else $error("fifo push lost");
	property p_rc_quiet;
		cfg_r[CFG_RC] && !rc_hit && !thr_evt && !adc_irq |=> !adc_irq;
	endproperty
	a_rc_quiet: assert property (p_rc_quiet) else $error("interrupt outside count");
	property p_rc_wrap;
		rc_hit && !cur_reconfig |=> rcv_r == '0;
	endproperty
	a_rc_wrap: assert property (p_rc_wrap) else $error("result counter not wrapped");
	property p_hold;
		rdy_r[CH_CUR] && !rdy_clr[CH_CUR] |=> $stable(ch_g[CH_CUR].dat_r);
	endproperty
	a_hold: assert property (p_hold) else $error("current result overwritten");
	property p_rd_clr;
		s_rd_cur_quiet |=> rdy_r == '0;
	endproperty
	a_rd_clr: assert property (p_rd_clr) else $error("ready flags not cleared");
	property p_fifo_rd;
		f_pop && !f_empty |=> s_axi_rdata == $past(f_head) ##1 1'b1;
	endproperty
	a_fifo_rd: assert property (p_fifo_rd) else $error("fifo read data wrong");
endmodule
`default_nettype wire

// ===== dv/adc_result_comparator_fifo_tb.sv
// Self-checking bench for the converter result block: registers over AXI4-Lite,
// converter strobes, comparator modes, FIFO, result count and overrange.
// Assumes the design's own assertions guard the cycle rules; this checks values.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module adc_result_comparator_fifo_tb
	import arcf_pkg::*;
;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic                aclk, aresetn;
	logic [31:0]         awaddr, wdata, araddr, rdata, rdv;
	logic                awvalid, awready, wvalid, wready, bvalid, bready;
	logic                arvalid, arready, rvalid, rready, irq;
	logic [1:0]          bresp, rresp, rsp, brs;
	logic [3:0]          wstrb;
	arcf_res_t [NCH-1:0] res_in;
	arcf_res_t           cofs_cal, vofs_cal;
	logic                cur_active, cur_reconfig, ovr_pin;
	int                  n_fail, cmp_count, cyc;

	arcf_top u_arcf_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .res_in(res_in),
		.cur_active(cur_active), .cur_reconfig(cur_reconfig), .ovr_pin(ovr_pin), .cofs_cal(cofs_cal),
		.vofs_cal(vofs_cal), .adc_irq(irq));

	// 25 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// ---------------------------------------------------------------
	// Bus and converter tasks, all entered just after a rising edge
	// ---------------------------------------------------------------
	// Ready is sampled at the falling edge, so the hand-off edge is known before it comes
	task wr(input logic [31:0] a, input logic [31:0] d);
		logic ad, wd, ta, tw;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd))
		begin
			@(negedge aclk);
			ta = !ad && awready;
			tw = !wd && wready;
			@(posedge aclk);
			if (ta) begin ad = 1'b1; awvalid <= 1'b0; end
			if (tw) begin wd = 1'b1; wvalid <= 1'b0; end
		end
		do @(negedge aclk); while (!bvalid);
		brs = bresp;
		@(posedge aclk);
	endtask

	task rd(input logic [31:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (!rvalid);
		rdv = rdata;
		rsp = rresp;
		@(posedge aclk);
	endtask

	// One-cycle result strobe; data stays put so voltage pairs with later current strobes
	task cv(input int ch, input logic [15:0] d);
		res_in[ch].vld <= 1'b1;
		res_in[ch].data <= d;
		@(posedge aclk);
		res_in[ch].vld <= 1'b0;
		@(posedge aclk);
	endtask

	task end_sim;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Hang guard: the run needs about 3400 cycles; forked from the test process so one place counts failures
	task watchdog;
		while (cyc < 20000)
		begin
			@(posedge aclk);
			cyc++;
		end
		n_fail++;
		$display("[FAIL] timeout exp %0d got %0d", 20000, cyc);
		end_sim();
	endtask

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial
	begin
		{awaddr, wdata, araddr, awvalid, wvalid, arvalid, cur_reconfig, ovr_pin, cur_active} = '0;
		{res_in, cofs_cal, vofs_cal, n_fail, cmp_count, cyc} = '0;
		{bready, rready, wstrb, aresetn} = 7'h7E;
		fork
			watchdog();
		join_none
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(A_CFG); `CHK("cfg", 8'h00, rdv[7:0])
		rd(A_TCL); `CHK("tcl", 8'h01, rdv[7:0])
		rd(A_RCL); `CHK("rcl", 16'h0001, rdv[15:0])
		rd(A_COFS); `CHK("cofs", 16'h8000, rdv[15:0])
		rd(A_VOFS); `CHK("vofs", 16'h8000, rdv[15:0])
		$display("test reset done");
		cv(0, 16'h1234); cv(0, 16'h5555); cv(2, 16'h0042); cv(1, 16'h0077);
		rd(A_STA); `CHK("sta", 8'h07, rdv[7:0])
		rd(A_TEMP); `CHK("temp", 16'h0042, rdv[15:0])
		rd(A_STA); `CHK("sta", 8'h03, rdv[7:0])
		cur_active <= 1'b1;
		rd(A_VOLT); `CHK("volt", 16'h0077, rdv[15:0])
		rd(A_STA); `CHK("sta", 8'h03, rdv[7:0])
		cur_active <= 1'b0;
		rd(A_VOLT); rd(A_STA); `CHK("sta", 8'h01, rdv[7:0])
		rd(A_CUR); `CHK("cur", 16'h1234, rdv[15:0])
		rd(A_STA); `CHK("sta", 8'h00, rdv[7:0])
		$display("test data done");
		wr(A_TH, 32'h64); wr(A_CFG, 32'h08); cv(0, 16'hFF9C);
		rd(A_STA); `CHK("evt", 1'b1, rdv[3])
		rd(A_CUR); wr(A_TCL, 32'h02); wr(A_CFG, 32'h10); cv(0, 16'h0005);
		rd(A_THV); `CHK("thv", 8'h00, rdv[7:0])
		cv(0, 16'h0064); cv(0, 16'hFF9C);
		rd(A_THV); `CHK("thv", 8'h02, rdv[7:0])
		rd(A_STA); `CHK("evt", 1'b1, rdv[3])
		wr(A_CFG, 32'h18); cv(0, 16'h0063);
		rd(A_THV); `CHK("thv", 8'h01, rdv[7:0])
		wr(A_CFG, 32'h00); cv(0, 16'h0064);
		rd(A_THV); `CHK("thv", 8'h01, rdv[7:0])
		rd(A_STA); `CHK("evt", 1'b0, rdv[3])
		$display("test comparator done");
		wr(A_RCL, 32'h03); wr(A_CFG, 32'h01); cv(0, 16'h0001);
		rd(A_RCV); `CHK("rcv", 16'h0001, rdv[15:0])
		cur_reconfig <= 1'b1;
		@(posedge aclk);
		cur_reconfig <= 1'b0;
		rd(A_RCV); `CHK("rcv", 16'h0000, rdv[15:0])
		rd(A_STA); cv(0, 16'h0001); cv(0, 16'h0002);
		@(negedge aclk); `CHK("irq", 1'b0, irq)
		@(posedge aclk);
		rd(A_RCV); `CHK("rcv", 16'h0002, rdv[15:0])
		cv(0, 16'h0003);
		@(negedge aclk); `CHK("irq", 1'b1, irq)
		@(posedge aclk);
		rd(A_RCV); `CHK("rcv", 16'h0000, rdv[15:0])
		$display("test result count done");
		wr(A_CFG, 32'h02); cv(1, 16'h0A0A); cv(0, 16'h0B0B); cv(1, 16'h0C0C); cv(0, 16'h0D0D);
		rd(A_STA); `CHK("nempty", 1'b1, rdv[5])
		rd(A_FIFO); `CHK("fifo", 32'h0A0A0B0B, rdv)
		rd(A_FIFO); `CHK("fifo", 32'h0C0C0D0D, rdv)
		rd(A_STA); `CHK("nempty", 1'b0, rdv[5])
		// Fill to exactly the depth and no further; a further push would be dropped and set the overflow flag
		for (int i = 0; i < 32; i++) cv(0, 16'(i));
		rd(A_STA); `CHK("fifo flags", 3'h3, rdv[7:5])
		rd(A_FIFO); `CHK("fifo", 32'h0C0C0000, rdv)
		$display("test fifo done");
		// Converters stay in normal power here, so the coarse detector may be enabled
		wr(A_CFG, 32'h04);
		ovr_pin <= 1'b1;
		repeat (3000) @(posedge aclk);
		rd(A_STA); `CHK("ovr", 1'b0, rdv[4])
		repeat (200) @(posedge aclk);
		rd(A_STA); `CHK("ovr", 1'b1, rdv[4])
		ovr_pin <= 1'b0;
		$display("test overrange done");
		// No conversion has run through the long overrange wait, so the converter is settled idle
		wr(A_COFS, 32'h1111); rd(A_COFS); `CHK("cofs", 16'h1111, rdv[15:0])
		cofs_cal <= '{1'b1, 16'h2222};
		vofs_cal <= '{1'b1, 16'h3333};
		@(posedge aclk);
		cofs_cal.vld <= 1'b0;
		vofs_cal.vld <= 1'b0;
		@(posedge aclk);
		rd(A_COFS); `CHK("cofs", 16'h2222, rdv[15:0])
		rd(A_VOFS); `CHK("vofs", 16'h3333, rdv[15:0])
		wr(A_CUR, 32'hFFFF); `CHK("bresp", RESP_OKAY, brs)
		rd(A_CUR); `CHK("cur", 16'h0005, rdv[15:0])
		rd(32'hFFFF0600); `CHK("rresp", RESP_DECERR, rsp)
		$display("test coefficients done");
		end_sim();
	end
endmodule
`default_nettype wire
